// *** rtl/mbsw_pkg.sv ***
// shared constants and carrier types of the modbus write and diagnostic handler
package mbsw_pkg;
  // function codes handled or named here
  localparam logic [7:0] FC_DIAG = 8'h08;
  localparam logic [7:0] FC_COIL_1 = 8'h05;
  localparam logic [7:0] FC_REG_1 = 8'h06;
  localparam logic [7:0] FC_COILS = 8'h0f;
  localparam logic [7:0] FC_REGS = 8'h10;
  localparam logic [7:0] FC_EXC_FLAG = 8'h80;
  localparam logic [15:0] SUB_LOOPBACK = 16'h0000;
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  // exception codes
  localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
  localparam logic [7:0] EXC_ILL_VALUE = 8'h03;
  // storage sizes
  localparam int N_COILS = 256;
  localparam int N_REGS = 128;
  localparam logic [16:0] COIL_LIMIT = 17'h00100;
  localparam logic [16:0] REG_LIMIT = 17'h00080;
  localparam logic [15:0] MAX_REGS = 16'h003c;
  localparam int BUF_DEPTH = 256;
  localparam logic [8:0] BUF_FULL = 9'h100;
  // request byte positions, crc already stripped by the framer
  localparam logic [7:0] POS_ADDR = 8'h00;
  localparam logic [7:0] POS_FUNC = 8'h01;
  localparam logic [7:0] POS_START = 8'h02;
  localparam logic [7:0] POS_QTY = 8'h04;
  localparam logic [7:0] POS_BCNT = 8'h06;
  localparam logic [7:0] POS_DATA = 8'h07;
  localparam logic [8:0] LEN_DIAG_MIN = 9'h004;
  localparam logic [8:0] LEN_ACK = 9'h006;
  localparam logic [8:0] LEN_EXC = 9'h003;
  localparam logic [8:0] LEN_MIN = 9'h002;
  // controller states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CHECK = 4'b0010,
    ST_EXEC = 4'b0100,
    ST_RESP = 4'b1000
  } mbsw_state_t;
  // receive byte stream from the framer
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic frame_end;
    logic crc_ok;
  } mbsw_rx_t;
  // transmit byte stream to the framer, which appends the crc
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } mbsw_tx_t;
endpackage

// *** rtl/mbsw_handler.sv ***
// modbus slave handler for loopback diagnostic, force coils and preset registers
module mbsw_handler (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] slave_addr_i,
  input wire mbsw_pkg::mbsw_rx_t rx_i,
  output mbsw_pkg::mbsw_tx_t tx_o,
  input wire logic tx_ready_i,
  input wire logic scan_coil_we_i,
  input wire logic [7:0] scan_coil_addr_i,
  input wire logic scan_coil_val_i,
  input wire logic scan_reg_we_i,
  input wire logic [6:0] scan_reg_addr_i,
  input wire logic [15:0] scan_reg_wdata_i,
  input wire logic [6:0] scan_reg_raddr_i,
  output logic [15:0] scan_reg_rdata_o,
  output logic [255:0] coils_o,
  output logic busy_o
);
  // true when start plus quantity runs past the limit
  function automatic logic out_of_range(input logic [15:0] start, input logic [15:0] qty,
                                        input logic [16:0] limit);
    out_of_range = ({1'b0, start} + {1'b0, qty}) > limit;
  endfunction
  mbsw_pkg::mbsw_state_t state_q; // controller state
  logic [7:0] buf_q [mbsw_pkg::BUF_DEPTH]; // request bytes, crc stripped
  logic [8:0] len_q; // bytes received
  logic ovf_q; // request longer than the buffer
  logic [255:0] coil_q; // coil storage, no reset
  logic [15:0] reg_q [mbsw_pkg::N_REGS]; // holding registers, no reset
  logic [15:0] reg_rdata_q; // scan read data
  logic exc_q; // reply is an exception
  logic [7:0] exc_code_q; // exception code to send
  logic [8:0] rlen_q; // reply length in bytes
  logic [7:0] tidx_q; // index of byte on tx
  logic [7:0] tdata_q; // byte on tx
  logic tlast_q; // last reply byte
  logic [8:0] wcnt_q; // write loop counter
  // header fields decoded from the buffer
  logic [7:0] fc;
  logic [15:0] start, qty, sub;
  logic bcast, mine;
  assign fc = buf_q[mbsw_pkg::POS_FUNC];
  assign start = {buf_q[mbsw_pkg::POS_START], buf_q[mbsw_pkg::POS_START + 8'h01]};
  assign sub = start;
  assign qty = {buf_q[mbsw_pkg::POS_QTY], buf_q[mbsw_pkg::POS_QTY + 8'h01]};
  assign bcast = buf_q[mbsw_pkg::POS_ADDR] == mbsw_pkg::BCAST_ADDR;
  assign mine = buf_q[mbsw_pkg::POS_ADDR] == slave_addr_i;
  // request verdict, worked out in the check state
  logic drop, do_exc, do_write, do_echo;
  logic [7:0] exc_code;
  logic [8:0] need_len;
  always_comb begin
    drop = 1'b0;
    do_exc = 1'b0;
    do_write = 1'b0;
    do_echo = 1'b0;
    exc_code = mbsw_pkg::EXC_ILL_FUNC;
    need_len = 9'(mbsw_pkg::POS_DATA) + 9'(buf_q[mbsw_pkg::POS_BCNT]);
    if (!rx_i.crc_ok || ovf_q || len_q < mbsw_pkg::LEN_MIN || !(mine || bcast)) begin
      drop = 1'b1;
    end else if (fc == mbsw_pkg::FC_DIAG) begin
      if (len_q >= mbsw_pkg::LEN_DIAG_MIN && sub == mbsw_pkg::SUB_LOOPBACK) begin
        do_echo = 1'b1;
      end else begin
        do_exc = 1'b1;
      end
    end else if (fc == mbsw_pkg::FC_COILS || fc == mbsw_pkg::FC_REGS) begin
      if (len_q < 9'(mbsw_pkg::POS_DATA) || len_q != need_len || qty == 16'h0000) begin
        do_exc = 1'b1;
        exc_code = mbsw_pkg::EXC_ILL_VALUE;
      end else if (fc == mbsw_pkg::FC_COILS) begin
        if (out_of_range(start, qty, mbsw_pkg::COIL_LIMIT)) begin
          do_exc = 1'b1;
          exc_code = mbsw_pkg::EXC_ILL_ADDR;
        end else if (buf_q[mbsw_pkg::POS_BCNT] != 8'((qty + 16'h0007) >> 3)) begin
          do_exc = 1'b1;
          exc_code = mbsw_pkg::EXC_ILL_VALUE;
        end else begin
          do_write = 1'b1;
        end
      end else if (qty > mbsw_pkg::MAX_REGS || buf_q[mbsw_pkg::POS_BCNT] != 8'(qty << 1)) begin
        do_exc = 1'b1;
        exc_code = mbsw_pkg::EXC_ILL_VALUE;
      end else if (out_of_range(start, qty, mbsw_pkg::REG_LIMIT)) begin
        do_exc = 1'b1;
        exc_code = mbsw_pkg::EXC_ILL_ADDR;
      end else begin
        do_write = 1'b1;
      end
    end else begin
      // single coil and register writes belong to another handler
      do_exc = 1'b1;
    end
    // broadcast only for writes and loopback
    if (bcast && do_exc) begin
      drop = 1'b1;
      do_exc = 1'b0;
    end
  end
  // reply byte at a given index
  logic [7:0] nidx;
  logic [7:0] nbyte;
  assign nidx = (state_q == mbsw_pkg::ST_RESP) ? tidx_q + 8'h01 : 8'h00;
  always_comb begin
    nbyte = buf_q[nidx];
    if (exc_q && nidx == 8'h01) begin
      nbyte = fc | mbsw_pkg::FC_EXC_FLAG;
    end else if (exc_q && nidx == 8'h02) begin
      nbyte = exc_code_q;
    end
  end
  // link write strobes during the write loop
  logic coil_we, reg_we, last_w;
  logic [7:0] coil_addr, coil_byte;
  logic [6:0] reg_addr;
  logic [15:0] reg_data;
  assign coil_addr = 8'(start + 16'(wcnt_q));
  assign reg_addr = 7'(start + 16'(wcnt_q));
  assign coil_byte = buf_q[8'(mbsw_pkg::POS_DATA + 8'(wcnt_q >> 3))];
  assign reg_data = {buf_q[8'(mbsw_pkg::POS_DATA + 8'(wcnt_q << 1))],
                     buf_q[8'(mbsw_pkg::POS_DATA + 8'(wcnt_q << 1) + 8'h01)]};
  assign coil_we = state_q == mbsw_pkg::ST_EXEC && fc == mbsw_pkg::FC_COILS;
  assign reg_we = state_q == mbsw_pkg::ST_EXEC && fc == mbsw_pkg::FC_REGS;
  assign last_w = 16'(wcnt_q) + 16'h0001 == qty;
  // main sequencer
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_q <= mbsw_pkg::ST_IDLE;
      len_q <= 9'h000;
      ovf_q <= 1'b0;
      wcnt_q <= 9'h000;
    end else begin
      case (state_q)
        mbsw_pkg::ST_IDLE: begin
          // collect; frame end arrives one cycle after the last byte
          if (rx_i.frame_end) begin
            state_q <= mbsw_pkg::ST_CHECK;
          end else if (rx_i.valid && len_q == mbsw_pkg::BUF_FULL) begin
            ovf_q <= 1'b1;
          end else if (rx_i.valid) begin
            len_q <= len_q + 9'h001;
          end
        end
        mbsw_pkg::ST_CHECK: begin
          wcnt_q <= 9'h000;
          if (do_write) begin
            state_q <= mbsw_pkg::ST_EXEC;
          end else if (drop || (bcast && do_echo)) begin
            state_q <= mbsw_pkg::ST_IDLE;
          end else begin
            state_q <= mbsw_pkg::ST_RESP;
          end
          if (drop || do_write || bcast) begin
            len_q <= 9'h000;
            ovf_q <= 1'b0;
          end
        end
        mbsw_pkg::ST_EXEC: begin
          wcnt_q <= wcnt_q + 9'h001;
          if (last_w) begin
            state_q <= bcast ? mbsw_pkg::ST_IDLE : mbsw_pkg::ST_RESP;
          end
        end
        mbsw_pkg::ST_RESP: begin
          if (tx_ready_i && tlast_q) begin
            state_q <= mbsw_pkg::ST_IDLE;
            len_q <= 9'h000;
            ovf_q <= 1'b0;
          end
        end
        default: state_q <= mbsw_pkg::ST_IDLE;
      endcase
    end
  end
  // request buffer, no reset needed
  always_ff @(posedge clk_i) begin
    if (state_q == mbsw_pkg::ST_IDLE && rx_i.valid && !rx_i.frame_end &&
        len_q != mbsw_pkg::BUF_FULL) begin
      buf_q[8'(len_q)] <= rx_i.data;
    end
  end
  // reply kind and length, fixed in the check state
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      exc_q <= 1'b0;
      exc_code_q <= 8'h00;
      rlen_q <= 9'h000;
    end else if (state_q == mbsw_pkg::ST_CHECK) begin
      exc_q <= do_exc;
      exc_code_q <= exc_code;
      rlen_q <= do_exc ? mbsw_pkg::LEN_EXC : (do_write ? mbsw_pkg::LEN_ACK : len_q);
    end
  end

  // reply byte stream; the framer appends the crc after the last byte
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      tidx_q <= 8'h00;
      tdata_q <= 8'h00;
      tlast_q <= 1'b0;
    end else if ((state_q == mbsw_pkg::ST_RESP && tx_ready_i) ||
                 (state_q != mbsw_pkg::ST_RESP)) begin
      tidx_q <= nidx;
      tdata_q <= nbyte;
      tlast_q <= 9'(nidx) + 9'h001 == rlen_q;
    end
  end
  assign tx_o.valid = state_q == mbsw_pkg::ST_RESP;
  assign tx_o.data = tdata_q;
  assign tx_o.last = tlast_q;
  assign busy_o = state_q != mbsw_pkg::ST_IDLE;

  // coil storage; link write wins a same-cycle clash with the scan
  // never cleared by reset
  always_ff @(posedge clk_i) begin
    if (scan_coil_we_i) begin
      coil_q[scan_coil_addr_i] <= scan_coil_val_i;
    end
    if (coil_we) begin
      coil_q[coil_addr] <= coil_byte[wcnt_q[2:0]];
    end
  end
  assign coils_o = coil_q;

  // holding registers, same priority as coils
  always_ff @(posedge clk_i) begin
    if (scan_reg_we_i) begin
      reg_q[scan_reg_addr_i] <= scan_reg_wdata_i;
    end
    if (reg_we) begin
      reg_q[reg_addr] <= reg_data;
    end
    reg_rdata_q <= reg_q[scan_reg_raddr_i];
  end
  assign scan_reg_rdata_o = reg_rdata_q;

  bcast_silent_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    tx_o.valid |-> !bcast) else $error("reply sent to broadcast");
  exc_function_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    tx_o.valid && exc_q && tidx_q == 8'h01 |-> tx_o.data == (fc | 8'h80))
    else $error("exception function byte wrong");
  loop_echo_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    tx_o.valid && !exc_q && fc == 8'h08 |-> tx_o.data == buf_q[tidx_q] && rlen_q == len_q)
    else $error("loopback reply differs");
  diag_nowrite_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    fc == 8'h08 |-> !coil_we && !reg_we) else $error("diagnostic wrote storage");
  ack_length_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(tx_o.valid) && !exc_q && fc != 8'h08 |-> rlen_q == 9'h006)
    else $error("write reply length wrong");
  crc_drop_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state_q == mbsw_pkg::ST_CHECK && !rx_i.crc_ok |=> state_q == mbsw_pkg::ST_IDLE [*2])
    else $error("bad crc frame handled");
  reg_lands_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    reg_we |=> reg_q[$past(reg_addr)] == $past(reg_data)) else $error("register write lost");
  reg_cap_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    reg_we |-> wcnt_q < 9'(mbsw_pkg::MAX_REGS)) else $error("register count over cap");
  coil_lands_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    coil_we |=> coil_q[$past(coil_addr)] == $past(coil_byte[wcnt_q[2:0]]))
    else $error("coil write lost");
  range_code_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state_q == mbsw_pkg::ST_CHECK && !drop && fc == 8'h0f && len_q == need_len &&
    qty != 16'h0000 && ({1'b0, start} + {1'b0, qty}) > 17'h00100 |=>
    exc_q && exc_code_q == 8'h02) else $error("range exception code wrong");
endmodule

// *** dv/mbsw_master_model.sv ***
// behavioural modbus master: sends request frames, takes reply bytes
module mbsw_master_model (
  input wire logic clk_i,
  input wire logic busy_i,
  input wire mbsw_pkg::mbsw_tx_t tx_i,
  output mbsw_pkg::mbsw_rx_t rx_o,
  output logic tx_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] reply_q[$]; // reply bytes taken so far
  int stall_n = 0; // 0 always ready, else ready one cycle in stall_n
  int cyc = 0; // free count for the stall pattern
  initial begin
    rx_o = '0;
  end
  // ready pattern and reply capture on the taking edge
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    tx_ready_o <= (stall_n == 0) || (cyc % stall_n == 0);
    if (tx_i.valid && tx_ready_o) begin
      reply_q.push_back(tx_i.data);
    end
  end
  // one request: bytes, then frame end alone with the crc verdict
  task automatic send_frame(input logic [7:0] req[$], input logic crc_good);
    int n;
    n = 0;
    // wait at most 500 cycles for the slave to leave busy, then start anyway
    while (busy_i && n < 500) begin
      @(posedge clk_i);
      n++;
    end
    foreach (req[i]) begin
      @(posedge clk_i);
      rx_o.valid <= 1'b1;
      rx_o.data <= req[i];
    end
    @(posedge clk_i);
    rx_o.valid <= 1'b0;
    // released data line must not keep the last byte
    rx_o.data <= ~req[req.size()-1];
    rx_o.frame_end <= 1'b1;
    rx_o.crc_ok <= crc_good;
    @(posedge clk_i);
    rx_o.frame_end <= 1'b0;
  endtask
endmodule

// *** dv/test_mbsw_handler.sv ***
// self-checking testbench of the modbus write and diagnostic handler
module test_mbsw_handler;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i;
  logic resetn_i;
  mbsw_pkg::mbsw_rx_t rx; // request stream from the master model
  mbsw_pkg::mbsw_tx_t tx; // reply stream to the master model
  logic tx_ready;
  logic busy;
  logic cwe;
  logic [7:0] caddr;
  logic cval;
  logic rwe;
  logic [6:0] raddr;
  logic [15:0] rwdata;
  logic [6:0] rraddr;
  logic [15:0] rdata;
  logic [255:0] coils;
  logic [7:0] req[$]; // request under test
  logic [7:0] exp[$]; // reply expected, empty for none
  int fail_count = 0;
  int samples_checked = 0;

  mbsw_handler dut_u (
    .clk_i(clk_i), .resetn_i(resetn_i), .slave_addr_i(8'h11), .rx_i(rx), .tx_o(tx),
    .tx_ready_i(tx_ready), .scan_coil_we_i(cwe), .scan_coil_addr_i(caddr),
    .scan_coil_val_i(cval), .scan_reg_we_i(rwe), .scan_reg_addr_i(raddr),
    .scan_reg_wdata_i(rwdata), .scan_reg_raddr_i(rraddr), .scan_reg_rdata_o(rdata),
    .coils_o(coils), .busy_o(busy)
  );
  mbsw_master_model master_u (
    .clk_i(clk_i), .busy_i(busy), .tx_i(tx), .rx_o(rx), .tx_ready_o(tx_ready)
  );

  // 200 mhz clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // watchdog: whole run is well under this span
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    give_verdict();
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] e);
    samples_checked++;
    if (seen !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, seen);
    end
  endtask
  // send req, wait for idle, compare the whole reply with exp
  task automatic run_frame(input logic crc_good);
    int n;
    master_u.reply_q.delete();
    master_u.send_frame(req, crc_good);
    n = 0;
    @(negedge clk_i);
    while (busy !== 1'b0 && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    // a dropped frame must stay silent a while longer too
    repeat (4) @(negedge clk_i);
    // a slave still busy here has hung; count it
    check("busy after frame", 32'(busy), 32'h0);
    check("reply length", 32'(master_u.reply_q.size()), 32'(exp.size()));
    foreach (exp[i]) begin
      if (i < master_u.reply_q.size()) begin
        check("reply byte", {24'h0, master_u.reply_q[i]}, {24'h0, exp[i]});
      end
    end
  endtask
  // scan side read has one cycle of latency
  task automatic reg_is(input logic [6:0] a, input logic [15:0] e);
    @(posedge clk_i);
    rraddr <= a;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    check("holding reg", {16'h0, rdata}, {16'h0, e});
  endtask

  task automatic test_coils();
    req = {8'h11, 8'h0f, 8'h00, 8'h13, 8'h00, 8'h0a, 8'h02, 8'hcd, 8'h01};
    exp = {8'h11, 8'h0f, 8'h00, 8'h13, 8'h00, 8'h0a};
    run_frame(1'b1);
    // start 13 hex counted from zero puts the block at coils 19..28
    check("coils 28..19", 32'(coils[28:19]), 32'h1cd);
    // scan logic clears coil 19 after the link write
    @(posedge clk_i);
    cwe <= 1'b1;
    caddr <= 8'd19;
    cval <= 1'b0;
    @(posedge clk_i);
    cwe <= 1'b0;
    @(negedge clk_i);
    check("coils 28..19", 32'(coils[28:19]), 32'h1cc);
    $display("coil test done");
  endtask

  task automatic test_regs();
    master_u.stall_n = 3;
    req = {8'h11, 8'h10, 8'h00, 8'h05, 8'h00, 8'h02, 8'h04, 8'h00, 8'h0a, 8'h01, 8'h02};
    exp = {8'h11, 8'h10, 8'h00, 8'h05, 8'h00, 8'h02};
    run_frame(1'b1);
    master_u.stall_n = 0;
    reg_is(7'd5, 16'h000a);
    reg_is(7'd6, 16'h0102);
    @(posedge clk_i);
    rwe <= 1'b1;
    raddr <= 7'd6;
    rwdata <= 16'h5a5a;
    @(posedge clk_i);
    rwe <= 1'b0;
    reg_is(7'd6, 16'h5a5a);
    $display("register test done");
  endtask

  task automatic test_loopback();
    req = {8'h11, 8'h08, 8'h00, 8'h00, 8'ha5, 8'h37};
    exp = req;
    run_frame(1'b1);
    check("coils 28..19", 32'(coils[28:19]), 32'h1cc);
    reg_is(7'd6, 16'h5a5a);
    $display("loopback test done");
  endtask

  task automatic test_exceptions();
    req = {8'h11, 8'h08, 8'h00, 8'h01, 8'ha5, 8'h37};
    exp = {8'h11, 8'h88, 8'h01};
    run_frame(1'b1);
    // start 7f plus two runs one past the last register
    req = {8'h11, 8'h10, 8'h00, 8'h7f, 8'h00, 8'h02, 8'h04, 8'h00, 8'h01, 8'h00, 8'h02};
    exp = {8'h11, 8'h90, 8'h02};
    run_frame(1'b1);
    req = {8'h11, 8'h0f, 8'h00, 8'hff, 8'h00, 8'h02, 8'h01, 8'h03};
    exp = {8'h11, 8'h8f, 8'h02};
    run_frame(1'b1);
    req = {8'h11, 8'h10, 8'h00, 8'h00, 8'h00, 8'h3d, 8'h00};
    exp = {8'h11, 8'h90, 8'h03};
    run_frame(1'b1);
    // single coil write is served elsewhere, so illegal function here
    req = {8'h11, 8'h05, 8'h00, 8'hac, 8'hff, 8'h00};
    exp = {8'h11, 8'h85, 8'h01};
    run_frame(1'b1);
    // ten coils need two data bytes, only one is sent
    req = {8'h11, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h0a, 8'h01, 8'hff};
    exp = {8'h11, 8'h8f, 8'h03};
    run_frame(1'b1);
    // diagnostic cut short before its sub-function low byte
    req = {8'h11, 8'h08, 8'h00};
    exp = {8'h11, 8'h88, 8'h01};
    run_frame(1'b1);
    $display("exception test done");
  endtask

  task automatic test_broadcast();
    exp = {};
    req = {8'h00, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h08, 8'h01, 8'ha5};
    run_frame(1'b1);
    check("coils 7..0", 32'(coils[7:0]), 32'ha5);
    req = {8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01};
    run_frame(1'b1);
    req = {8'h00, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34};
    run_frame(1'b1);
    check("coils 7..0", 32'(coils[7:0]), 32'ha5);
    $display("broadcast test done");
  endtask

  task automatic test_drops();
    exp = {};
    req = {8'h11, 8'h08, 8'h00, 8'h00};
    run_frame(1'b0);
    req = {8'h12, 8'h08, 8'h00, 8'h00};
    run_frame(1'b1);
    // coil states must outlive a reset
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(negedge clk_i);
    check("coils 28..19", 32'(coils[28:19]), 32'h1cc);
    $display("drop and reset test done");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // reset, then the scenarios in order
  initial begin
    resetn_i = 1'b0;
    cwe = 1'b0;
    caddr = 8'h00;
    cval = 1'b0;
    rwe = 1'b0;
    raddr = 7'h00;
    rwdata = 16'h0000;
    rraddr = 7'h00;
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    test_coils();
    test_regs();
    test_loopback();
    test_exceptions();
    test_broadcast();
    test_drops();
    give_verdict();
  end
endmodule
